// file: rtl/sfpcs_pkg.sv
// Package: SIMD FP control/status layout, element format and constants
package sfpcs_pkg;
  localparam int LANES = 4;
  localparam int BYTES = 16;
  localparam int ELEM_W = 32;
  localparam logic [7:0] EXP_BIAS = 8'h7f;
  localparam logic [7:0] EXP_ONES = 8'hff;
  localparam logic [9:0] EXP_DEN_MIN = 10'h382;
  // Exception flag and mask bit positions within their 6-bit fields
  localparam int EXC_INV = 0;
  localparam int EXC_DEN = 1;
  localparam int EXC_DIV = 2;
  localparam int EXC_OVF = 3;
  localparam int EXC_UNF = 4;
  localparam int EXC_PRE = 5;
  localparam logic [31:0] CSR_RESET = 32'h0000_1f80;
  localparam logic [31:0] CSR_RSVD_MASK = 32'hffff_0040;
  localparam logic [31:0] QNAN_DEFAULT = 32'hffc0_0000;
  localparam logic [15:0] ACC32_BYTES = 16'h000f;
  localparam logic [15:0] ACC128_BYTES = 16'hffff;

  // Bit 31 down to bit 0 of the control/status word
  typedef struct packed {
    logic [15:0] rsvd_hi;
    logic flush_underflow_enable;
    logic [1:0] round_select;
    logic [5:0] mask;
    logic rsvd6;
    logic [5:0] flags;
  } sfpcs_csr_t;

  typedef enum logic [1:0] {
    RND_NEAREST = 2'b00,
    RND_DOWN = 2'b01,
    RND_UP = 2'b10,
    RND_ZERO = 2'b11
  } sfpcs_round_t;

  typedef enum logic [2:0] {
    CLS_ZERO = 3'b000,
    CLS_DENORM = 3'b001,
    CLS_NORMAL = 3'b010,
    CLS_INF = 3'b011,
    CLS_SNAN = 3'b100,
    CLS_QNAN = 3'b101
  } sfpcs_class_t;

  typedef struct packed {
    logic sign;
    logic [7:0] exp;
    logic [22:0] frac;
  } sfpcs_elem_t;

  typedef sfpcs_elem_t [LANES-1:0] sfpcs_vec_t;
  typedef logic [BYTES-1:0][7:0] sfpcs_bytes_t;

  typedef struct packed {
    logic scalar;
    logic [LANES-1:0][5:0] exc;
    logic [LANES-1:0] tiny;
    sfpcs_vec_t result;
    sfpcs_vec_t first;
  } sfpcs_op_t;
endpackage

// file: rtl/sfpcs_top.sv
// Module: SIMD FP control/status register and result post-processing
// Operation
// - Packed operand is 128 bits, bit 0 LSB
// - Bytes little endian at consecutive addresses
// - Full 128-bit access for packed operations
// - 32-bit access for scalar operations
// - Element: sign, 8-bit exponent, 23-bit fraction
// - Exponent biased by 127
// - Implicit integer bit one except zero/denormal
// - Classify zero, denormal and infinity encodings
// - All-ones exponent, nonzero fraction: NaN kinds
// - Masked invalid yields default quiet NaN
// - Each element stored as four bytes
// - Load/restore write, store/save read register
// - Six sticky flags cleared only by load or reset
// - Unmasking a set flag raises nothing
// - One flag per exception type only
// - Reset clears all exception flags
// - Masks in bits 12-7, set suppresses
// - Reset sets every mask bit
// - Rounding in bits 14-13, reset nearest
// - Bit 15 enables flush, reset clear
// - Reserved bits nonzero write faults, no update
// - Rounding field decodes to four modes
// - Masked flush gives signed zero, sets flags
// - Element 0 in least significant 32 bits
module sfpcs_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register load and restore
  input wire logic csr_ld_valid,
  input wire logic csr_ld_restore,
  input wire logic [31:0] csr_ld_data,
  // Register store and save
  input wire logic csr_st_valid,
  input wire logic csr_st_save,
  // Operation result from the arithmetic datapath
  input wire logic op_valid,
  input wire sfpcs_pkg::sfpcs_op_t op,
  // Register view
  output sfpcs_pkg::sfpcs_csr_t csr_q,
  output sfpcs_pkg::sfpcs_round_t round_mode_q,
  output logic flush_enable_q,
  output logic gp_fault_q,
  output logic gp_fault_restore_q,
  output logic store_valid_q,
  output logic store_save_q,
  output logic [31:0] store_data_q,
  output logic [3:0][7:0] store_bytes_q,
  // Post-processed result
  output logic res_valid_q,
  output sfpcs_pkg::sfpcs_vec_t res_data_q,
  output sfpcs_pkg::sfpcs_bytes_t res_bytes_q,
  output logic [15:0] res_byte_en_q,
  output sfpcs_pkg::sfpcs_class_t [3:0] res_class_q,
  output logic [9:0] res_exp0_q,
  output logic [23:0] res_sig0_q,
  output logic exc_raise_q,
  output logic [5:0] exc_cause_q
);
  import sfpcs_pkg::*;

  function automatic sfpcs_class_t classify(input sfpcs_elem_t e);
    sfpcs_class_t c;
    c = CLS_NORMAL;
    if (e.exp == 8'h00) begin
      c = (e.frac == 23'h000000) ? CLS_ZERO : CLS_DENORM;
    end else if (e.exp == EXP_ONES) begin
      if (e.frac == 23'h000000) begin
        c = CLS_INF;
      end else begin
        c = e.frac[22] ? CLS_QNAN : CLS_SNAN;
      end
    end
    return c;
  endfunction

  // Zero and denormals carry a hidden zero, all others a hidden one
  function automatic logic implicit_bit(input sfpcs_elem_t e);
    return e.exp != 8'h00;
  endfunction

  // Denormals share the smallest normal exponent
  function automatic logic [9:0] unbias(input sfpcs_elem_t e);
    logic [9:0] r;
    r = {2'b00, e.exp} - {2'b00, EXP_BIAS};
    if (e.exp == 8'h00) begin
      r = EXP_DEN_MIN;
    end
    return r;
  endfunction

  // Byte k sits at base address plus k
  function automatic sfpcs_bytes_t to_bytes(input sfpcs_vec_t v);
    sfpcs_bytes_t b;
    logic [127:0] flat;
    flat = v;
    for (int k = 0; k < BYTES; k++) begin
      b[k] = flat[8*k +: 8];
    end
    return b;
  endfunction

  logic ld_ok;
  logic [3:0] lane_act;
  logic [3:0][5:0] lane_exc;
  logic [5:0] det;
  logic [5:0] unmasked;
  sfpcs_vec_t res_d;
  sfpcs_csr_t csr_d;

  // Reserved bits are checked against the whole written word
  assign ld_ok = csr_ld_valid &&
    ((csr_ld_data & CSR_RSVD_MASK) == 32'h0000_0000);

  // Scalar work touches element 0 only
  assign lane_act = op.scalar ? 4'h1 : 4'hf;

  genvar gi;
  generate
    for (gi = 0; gi < LANES; gi++) begin : g_lane
      logic ftz;
      // Unmasked underflow wins over flushing
      assign ftz = csr_q.flush_underflow_enable && op.tiny[gi] &&
        csr_q.mask[EXC_UNF];
      always_comb begin
        lane_exc[gi] = op.exc[gi];
        if (ftz) begin
          lane_exc[gi][EXC_UNF] = 1'b1;
          lane_exc[gi][EXC_PRE] = 1'b1;
        end
        if (!lane_act[gi]) begin
          lane_exc[gi] = 6'h00;
        end
      end
      always_comb begin
        if (!lane_act[gi]) begin
          res_d[gi] = op.first[gi];
        end else if (op.exc[gi][EXC_INV] && csr_q.mask[EXC_INV]) begin
          res_d[gi] = QNAN_DEFAULT;
        end else if (ftz) begin
          res_d[gi] = {op.result[gi].sign, 31'h0000_0000};
        end else begin
          res_d[gi] = op.result[gi];
        end
      end
    end
  endgenerate

  // Identical events in several elements fold into one flag
  always_comb begin
    det = 6'h00;
    for (int i = 0; i < LANES; i++) begin
      det = det | lane_exc[i];
    end
  end

  // Masks are those in force before any load in the same cycle
  assign unmasked = det & ~csr_q.mask;

  // A load's clear loses to a flag raised in the same cycle
  always_comb begin
    csr_d = csr_q;
    if (ld_ok) begin
      csr_d = sfpcs_csr_t'(csr_ld_data);
    end
    if (op_valid) begin
      csr_d.flags = csr_d.flags | det;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      csr_q <= sfpcs_csr_t'(CSR_RESET);
      round_mode_q <= RND_NEAREST;
      flush_enable_q <= 1'b0;
    end else begin
      csr_q <= csr_d;
      round_mode_q <= sfpcs_round_t'(csr_d.round_select);
      flush_enable_q <= csr_d.flush_underflow_enable;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gp_fault_q <= 1'b0;
      gp_fault_restore_q <= 1'b0;
    end else begin
      gp_fault_q <= csr_ld_valid && !ld_ok;
      gp_fault_restore_q <= csr_ld_valid && !ld_ok && csr_ld_restore;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      store_valid_q <= 1'b0;
      store_save_q <= 1'b0;
      store_data_q <= 32'h0000_0000;
      store_bytes_q <= 32'h0000_0000;
    end else begin
      store_valid_q <= csr_st_valid;
      store_save_q <= csr_st_valid && csr_st_save;
      if (csr_st_valid) begin
        store_data_q <= csr_q;
        store_bytes_q <= csr_q;
      end
    end
  end

  // Only raise on an operation, never on a load that unmasks
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      exc_raise_q <= 1'b0;
      exc_cause_q <= 6'h00;
    end else begin
      exc_raise_q <= op_valid && (unmasked != 6'h00);
      exc_cause_q <= op_valid ? unmasked : 6'h00;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      res_valid_q <= 1'b0;
      res_data_q <= '0;
      res_bytes_q <= '0;
      res_byte_en_q <= 16'h0000;
      for (int i = 0; i < LANES; i++) begin
        res_class_q[i] <= CLS_ZERO;
      end
      res_exp0_q <= 10'h000;
      res_sig0_q <= 24'h000000;
    end else begin
      res_valid_q <= op_valid;
      if (op_valid) begin
        res_data_q <= res_d;
        res_bytes_q <= to_bytes(res_d);
        res_byte_en_q <= op.scalar ? ACC32_BYTES : ACC128_BYTES;
        for (int i = 0; i < LANES; i++) begin
          res_class_q[i] <= classify(res_d[i]);
        end
        res_exp0_q <= unbias(res_d[0]);
        res_sig0_q <= {implicit_bit(res_d[0]), res_d[0].frac};
      end
    end
  end

  reset_value_a: assert property (@(posedge clk_sys)
    $fell(rst) |-> csr_q == CSR_RESET)
    else $error("control/status not at reset value");

  flag_sticky_a: assert property (@(posedge clk_sys)
    disable iff (rst)
    !ld_ok |=> (csr_q.flags & $past(csr_q.flags)) == $past(csr_q.flags))
    else $error("sticky flag dropped without a load");

  rsvd_fault_a: assert property (@(posedge clk_sys)
    disable iff (rst)
    csr_ld_valid && !ld_ok |=> gp_fault_q &&
      csr_q.mask == $past(csr_q.mask) &&
      csr_q.round_select == $past(csr_q.round_select))
    else $error("reserved write not faulted or register changed");

  rsvd_zero_a: assert property (@(posedge clk_sys)
    disable iff (rst)
    (csr_q & CSR_RSVD_MASK) == 32'h0000_0000)
    else $error("reserved bits not zero");

  default_qnan_a: assert property (@(posedge clk_sys)
    disable iff (rst)
    op_valid && op.exc[0][EXC_INV] && csr_q.mask[EXC_INV]
      |=> res_data_q[0] == QNAN_DEFAULT && csr_q.flags[EXC_INV])
    else $error("masked invalid did not give default NaN");

  raise_unmasked_a: assert property (@(posedge clk_sys)
    disable iff (rst)
    op_valid && op.exc[0][EXC_DIV] && !csr_q.mask[EXC_DIV]
      |=> exc_raise_q && exc_cause_q[EXC_DIV] && csr_q.flags[EXC_DIV])
    else $error("unmasked exception not raised");

  no_raise_a: assert property (@(posedge clk_sys)
    disable iff (rst)
    !op_valid |=> !exc_raise_q ##1 (!$past(op_valid) || res_valid_q))
    else $error("exception raised without an operation");

  flush_zero_a: assert property (@(posedge clk_sys)
    disable iff (rst)
    op_valid && csr_q.flush_underflow_enable && csr_q.mask[EXC_UNF] &&
      op.tiny[0] && !op.exc[0][EXC_INV]
      |=> res_data_q[0][30:0] == 31'h0000_0000 &&
        csr_q.flags[EXC_UNF] && csr_q.flags[EXC_PRE])
    else $error("flush to zero not applied");

  scalar_pass_a: assert property (@(posedge clk_sys)
    disable iff (rst)
    op_valid && op.scalar |=> res_data_q[3:1] == $past(op.first[3:1]) &&
      res_byte_en_q == ACC32_BYTES)
    else $error("scalar upper elements not passed through");

  store_echo_a: assert property (@(posedge clk_sys)
    disable iff (rst)
    csr_st_valid |=> store_valid_q && store_data_q == $past(csr_q))
    else $error("store did not return the register");

  round_decode_a: assert property (@(posedge clk_sys)
    disable iff (rst)
    ld_ok && !op_valid |=> round_mode_q == $past(csr_ld_data[14:13]))
    else $error("rounding mode not decoded from load");

  reset_modes_a: assert property (@(posedge clk_sys)
    $fell(rst) |-> round_mode_q == RND_NEAREST && !flush_enable_q &&
      !res_valid_q && !exc_raise_q && !gp_fault_q)
    else $error("mode or pulse outputs not at reset value");

  load_write_a: assert property (@(posedge clk_sys)
    disable iff (rst)
    ld_ok && !op_valid |=> csr_q == $past(csr_ld_data))
    else $error("accepted load did not reach the register");

  mask_quiet_a: assert property (@(posedge clk_sys)
    disable iff (rst)
    op_valid && ((det & csr_q.mask) == det) |=> !exc_raise_q)
    else $error("masked exception was raised");

  flag_fold_a: assert property (@(posedge clk_sys)
    disable iff (rst)
    op_valid && !op.scalar && op.exc[1][EXC_INV] |=> csr_q.flags[EXC_INV])
    else $error("element exception did not set its flag");

  cause_idle_a: assert property (@(posedge clk_sys)
    disable iff (rst)
    !op_valid |=> exc_cause_q == 6'h00)
    else $error("exception cause without an operation");

  packed_width_a: assert property (@(posedge clk_sys)
    disable iff (rst)
    op_valid && !op.scalar |=> res_byte_en_q == ACC128_BYTES)
    else $error("packed result not full width");

  store_order_a: assert property (@(posedge clk_sys)
    disable iff (rst)
    store_valid_q |-> store_bytes_q[0] == store_data_q[7:0] &&
      store_bytes_q[3] == store_data_q[31:24])
    else $error("stored word bytes out of order");

  byte_layout_a: assert property (@(posedge clk_sys)
    disable iff (rst)
    res_valid_q |-> res_bytes_q[3:0] == res_data_q[0] &&
      res_bytes_q[15:12] == res_data_q[3])
    else $error("element bytes out of place");

  class_zero_a: assert property (@(posedge clk_sys)
    disable iff (rst)
    res_valid_q && res_data_q[0][30:0] == 31'h0000_0000
      |-> res_class_q[0] == CLS_ZERO)
    else $error("zero element misclassified");

  implicit_one_a: assert property (@(posedge clk_sys)
    disable iff (rst)
    res_valid_q && res_data_q[0].exp != 8'h00 |-> res_sig0_q[23])
    else $error("implicit integer bit missing");
endmodule

// file: tb/sfpcs_pipe_model.sv
// Pipeline model that issues register and operation requests
module sfpcs_pipe_model (
  // Clock
  input wire logic clk_sys,
  // Register requests
  output logic ld_valid,
  output logic ld_restore,
  output logic [31:0] ld_data,
  output logic st_valid,
  output logic st_save,
  // Operation results
  output logic op_valid,
  output sfpcs_pkg::sfpcs_op_t op
);
  timeunit 1ns;
  timeprecision 1ps;
  import sfpcs_pkg::*;

  initial begin
    ld_valid = 1'b0;
    ld_restore = 1'b0;
    ld_data = 32'h0;
    st_valid = 1'b0;
    st_save = 1'b0;
    op_valid = 1'b0;
    op = '0;
  end

  // Data is scrambled on release so a stale word never looks valid
  task automatic load(input logic [31:0] d, input logic rs);
    @(negedge clk_sys);
    ld_valid = 1'b1;
    ld_restore = rs;
    ld_data = d;
    @(negedge clk_sys);
    ld_valid = 1'b0;
    ld_data = ~d;
  endtask

  task automatic store(input logic sv);
    @(negedge clk_sys);
    st_valid = 1'b1;
    st_save = sv;
    @(negedge clk_sys);
    st_valid = 1'b0;
  endtask

  task automatic issue(input sfpcs_op_t o);
    @(negedge clk_sys);
    op_valid = 1'b1;
    op = o;
    @(negedge clk_sys);
    op_valid = 1'b0;
    op = ~o;
  endtask
endmodule

// file: tb/sfpcs_top_bench.sv
// Self-checking bench for the control/status register block
module sfpcs_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import sfpcs_pkg::*;

  logic clk_sys;
  logic rst;
  logic ld_v, ld_r, st_v, st_s, op_v;
  logic [31:0] ld_d;
  sfpcs_op_t op_w, o;
  sfpcs_csr_t csr_q;
  sfpcs_round_t round_mode_q;
  logic flush_enable_q, gp_fault_q, gp_fault_restore_q;
  logic store_valid_q, store_save_q, res_valid_q, exc_raise_q;
  logic [31:0] store_data_q;
  logic [3:0][7:0] store_bytes_q;
  sfpcs_vec_t res_data_q;
  sfpcs_bytes_t res_bytes_q;
  logic [15:0] res_byte_en_q;
  sfpcs_class_t [3:0] res_class_q;
  logic [9:0] res_exp0_q;
  logic [23:0] res_sig0_q;
  logic [5:0] exc_cause_q;
  int fails = 0;
  int compares = 0;

  sfpcs_pipe_model pipe (.clk_sys(clk_sys), .ld_valid(ld_v),
    .ld_restore(ld_r), .ld_data(ld_d), .st_valid(st_v), .st_save(st_s),
    .op_valid(op_v), .op(op_w));

  sfpcs_top dut (.clk_sys(clk_sys), .rst(rst), .csr_ld_valid(ld_v),
    .csr_ld_restore(ld_r), .csr_ld_data(ld_d), .csr_st_valid(st_v),
    .csr_st_save(st_s), .op_valid(op_v), .op(op_w), .csr_q(csr_q),
    .round_mode_q(round_mode_q), .flush_enable_q(flush_enable_q),
    .gp_fault_q(gp_fault_q), .gp_fault_restore_q(gp_fault_restore_q),
    .store_valid_q(store_valid_q), .store_save_q(store_save_q),
    .store_data_q(store_data_q), .store_bytes_q(store_bytes_q),
    .res_valid_q(res_valid_q), .res_data_q(res_data_q),
    .res_bytes_q(res_bytes_q), .res_byte_en_q(res_byte_en_q),
    .res_class_q(res_class_q), .res_exp0_q(res_exp0_q),
    .res_sig0_q(res_sig0_q), .exc_raise_q(exc_raise_q),
    .exc_cause_q(exc_cause_q));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [127:0] got, input logic [127:0] exp,
                     input string m);
    compares++;
    if (got !== exp) begin
      $display("unexpected at %0t: %s", $time, m);
      fails++;
    end
  endtask

  task automatic end_sim();
    if (fails == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic t_reset();
    chk(csr_q, CSR_RESET, "reset word");
    chk(round_mode_q, RND_NEAREST, "reset rounding");
    chk(flush_enable_q, 1'b0, "reset flush");
  endtask

  task automatic t_modes();
    logic [31:0] w;
    for (int i = 0; i < 4; i++) begin
      w = 32'h1f80 | (i << 13);
      pipe.load(w, i[0]);
      chk(round_mode_q, i, "rounding decode");
      pipe.store(i[1]);
      chk(store_valid_q, 1'b1, "store valid");
      chk(store_save_q, i[1], "store kind");
      chk(store_data_q, w, "store word");
      chk(store_bytes_q[1], w[15:8], "store byte order");
    end
  endtask

  task automatic t_fault();
    pipe.load(CSR_RESET, 1'b0);
    pipe.load(32'h0001_1f80, 1'b1);
    chk(gp_fault_q, 1'b1, "fault high bits");
    chk(gp_fault_restore_q, 1'b1, "fault source");
    pipe.load(32'h0000_1fc0, 1'b0);
    chk(gp_fault_q, 1'b1, "fault bit six");
    chk(gp_fault_restore_q, 1'b0, "fault source load");
    chk(csr_q, CSR_RESET, "word kept");
  endtask

  task automatic t_values();
    o = '0;
    o.result = {32'h0, 32'h1, 32'h3f00_0000, 32'h4000_0000};
    o.exc[0][EXC_INV] = 1'b1;
    o.exc[1][EXC_INV] = 1'b1;
    pipe.issue(o);
    chk(res_valid_q, 1'b1, "result valid");
    chk(res_data_q[1:0], {2{QNAN_DEFAULT}}, "default nan");
    chk(exc_raise_q, 1'b0, "masked raise");
    chk(csr_q.flags, 6'h01, "one flag");
    chk(res_class_q[3:2], {CLS_ZERO, CLS_DENORM}, "zero den");
    chk(res_byte_en_q, 16'hffff, "packed width");
    o = '0;
    o.result = {32'h7fc0_0000, 32'h7f80_0001, 32'h7f80_0000, 32'h3f80_0000};
    pipe.issue(o);
    chk(res_class_q, {CLS_QNAN, CLS_SNAN, CLS_INF, CLS_NORMAL},
      "classes");
    chk(res_exp0_q, 10'h000, "bias");
    chk(res_sig0_q, 24'h80_0000, "implicit one");
    chk(res_data_q[0], 32'h3f80_0000, "element 0");
    chk(res_bytes_q[7:4], 32'h7f80_0000, "byte view");
    chk(csr_q.flags, 6'h01, "sticky flag");
    o = '0;
    o.result = {32'h0, 32'h0, 32'h0, 32'h0000_0001};
    pipe.issue(o);
    chk(res_exp0_q, EXP_DEN_MIN, "denorm exponent");
    chk(res_sig0_q, 24'h00_0001, "denorm integer");
  endtask

  task automatic t_unmask();
    pipe.load(32'h1f01, 1'b0);
    @(negedge clk_sys);
    chk(exc_raise_q, 1'b0, "no raise on unmask");
    o = '0;
    o.result[0] = 32'h7f80_0001;
    o.exc[0][EXC_INV] = 1'b1;
    pipe.issue(o);
    chk(exc_raise_q, 1'b1, "raise");
    chk(exc_cause_q, 6'h01, "cause");
    chk(res_data_q[0], 32'h7f80_0001, "raw result");
    pipe.load(32'h1f80, 1'b0);
    chk(csr_q.flags, 6'h00, "flags cleared");
  endtask

  task automatic t_flush();
    pipe.load(32'h9f80, 1'b1);
    chk(flush_enable_q, 1'b1, "flush on");
    o = '0;
    o.scalar = 1'b1;
    o.first = {32'h1111_1111, 32'h2222_2222, 32'h3333_3333, 32'h4};
    o.result = {32'h5, 32'h6, 32'h7, 32'h8000_0001};
    o.tiny[0] = 1'b1;
    o.exc[0][EXC_UNF] = 1'b1;
    o.exc[1][EXC_DIV] = 1'b1;
    pipe.issue(o);
    chk(res_data_q[0], 32'h8000_0000, "signed zero");
    chk(res_data_q[3:1], o.first[3:1], "upper pass");
    chk(res_byte_en_q, 16'h000f, "scalar width");
    chk(csr_q.flags, 6'h30, "flush flags");
  endtask

  // Reset in mid-run with every field away from its reset value
  task automatic t_rerst();
    pipe.load(32'h0000_e03f, 1'b0);
    @(negedge clk_sys);
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    chk(csr_q, CSR_RESET, "mid-run reset word");
    chk(round_mode_q, RND_NEAREST, "mid-run rounding");
    chk(flush_enable_q, 1'b0, "mid-run flush");
    o = '0;
    o.exc[2][EXC_OVF] = 1'b1;
    pipe.issue(o);
    chk(exc_raise_q, 1'b0, "masked after reset");
    chk(csr_q.flags, 6'h08, "flag after reset");
  endtask

  initial begin
    rst = 1'b1;
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
    t_reset();
    t_modes();
    t_fault();
    t_values();
    t_unmask();
    t_flush();
    t_rerst();
    end_sim();
  end

  // Cuts a hang short
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    end_sim();
  end
endmodule
